// >>> inc/rfc_pkg.sv
package rfc_pkg;
  localparam int DATA_BYTES = 16;
  localparam int MTY_W = 4;
  localparam int LANES = 20;
  localparam int LANE_W = 5;
  localparam int RUNT_BYTES = 64;
  localparam int STAGE_WORDS = RUNT_BYTES / DATA_BYTES;
  localparam int FIFO_DEPTH = 4;
  localparam int LEVEL_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [14:0] MAX_LEN_RST = 15'h2580;
  localparam logic [7:0] MIN_LEN_RST = 8'h40;
  localparam logic [15:0] SPACING_RST = 16'h3FFF;
  // the two parity bytes of a marker change from block to block
  localparam logic [63:0] MARKER_CMP_MASK = 64'hFFFFFF00FFFFFF00;
  localparam logic [LANES-1:0][63:0] MARKER_RST = {
    64'hC0F0E5003F0F1A00, 64'h5F662A00A099D500, 64'hADD6B70052294800,
    64'hC4314C003BCEB300, 64'h3536CD00CAC93200, 64'h83C7CA007C383500,
    64'h1AF8BD00E5074200, 64'h5CB9B200A3464D00, 64'hB9915500466EAA00,
    64'hFD6C990002936600, 64'h68C9FB0097360400, 64'hA02476005FDB8900,
    64'h7B45660084BA9900, 64'h9A4A260065B5D900, 64'hDD14C20022EB3D00,
    64'hF50709000AF8F600, 64'h4D957B00B26A8400, 64'h594BE800A6B41700,
    64'h9D718E00628E7100, 64'hC16821003E97DE00};

  typedef enum logic [1:0] {
    ST_GATHER = 2'b00,
    ST_DRAIN = 2'b01,
    ST_PASS = 2'b10,
    ST_DISCARD = 2'b11
  } rfc_state_e;

  typedef struct packed {
    logic [DATA_BYTES*8-1:0] data;
    logic [MTY_W-1:0] mty;
    logic sop;
    logic eop;
    logic err;
  } rfc_word_s;
endpackage

// >>> inc/rfc_stream_if.sv
`timescale 1ns/100ps
interface rfc_stream_if #(parameter int WIDTH = 8, parameter int LEVEL_W = 3);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  logic [LEVEL_W-1:0] level;
  modport src (output data, output valid, input ready, input level);
  modport snk (input data, input valid, output ready, output level);
endinterface

// >>> hdl/rfc_fifo.sv
`timescale 1ns/100ps
module rfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int LEVEL_W = 3
) (
  input wire logic mclk,
  input wire logic reset,
  rfc_stream_if.snk wr,
  rfc_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LEVEL_W-1:0] cnt;
  } rfc_fifo_s;

  rfc_fifo_s fifo_q;
  rfc_fifo_s fifo_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    fifo_d = fifo_q;
    push = wr.valid && (fifo_q.cnt != LEVEL_W'(DEPTH));
    pop = rd.ready && (fifo_q.cnt != '0);
    if (push) begin
      fifo_d.mem[fifo_q.wp] = wr.data;
      fifo_d.wp = bump(fifo_q.wp);
    end
    if (pop) begin
      fifo_d.rp = bump(fifo_q.rp);
    end
    fifo_d.cnt = fifo_q.cnt + LEVEL_W'(push) - LEVEL_W'(pop);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fifo_q <= '0;
    end else begin
      fifo_q <= fifo_d;
    end
  end

  assign wr.ready = (fifo_q.cnt != LEVEL_W'(DEPTH));
  assign wr.level = fifo_q.cnt;
  assign rd.valid = (fifo_q.cnt != '0);
  assign rd.data = fifo_q.mem[fifo_q.rp];

  chk_fifo_level_bound: assert property (@(posedge mclk) disable iff (reset)
    fifo_q.cnt <= LEVEL_W'(DEPTH)) else $error("fifo level above depth");
  chk_fifo_full_hold: assert property (@(posedge mclk) disable iff (reset)
    !wr.ready && !rd.ready |=> !wr.ready && $stable(rd.data)) else $error("full fifo changed without a pop");
endmodule

// >>> hdl/rfc_rx_check.sv
`timescale 1ns/100ps
module rfc_rx_check (
  input wire logic mclk,
  input wire logic reset,
  input wire logic rx_ignore_fcs,
  input wire logic [14:0] rx_max_packet_len,
  input wire logic [7:0] rx_min_packet_len,
  input wire logic [15:0] rx_marker_spacing_less_one,
  input wire logic [rfc_pkg::LANES-1:0][63:0] rx_lane_marker_pattern,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [rfc_pkg::DATA_BYTES*8-1:0] in_data,
  input wire logic [rfc_pkg::MTY_W-1:0] in_mty,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic in_fcs_bad,
  input wire logic rx_user_ready,
  output logic rx_user_valid_out,
  output logic [rfc_pkg::DATA_BYTES*8-1:0] rx_user_data_out,
  output logic [rfc_pkg::MTY_W-1:0] rx_user_mty_out,
  output logic rx_user_sop_out,
  output logic rx_user_eop_out,
  output logic rx_user_err_out,
  output logic stat_rx_bad_fcs,
  output logic stat_rx_good_pkt,
  output logic stat_rx_runt_drop,
  output logic stat_rx_oversize,
  input wire logic lane_blk_valid,
  input wire logic [63:0] lane_blk_data,
  output logic lane_locked_out,
  output logic [rfc_pkg::LANE_W-1:0] lane_id_out
);
  localparam int WORD_W = $bits(rfc_pkg::rfc_word_s);
  localparam logic [15:0] RUNT16 = 16'(rfc_pkg::RUNT_BYTES);
  localparam logic [15:0] WORD16 = 16'(rfc_pkg::DATA_BYTES);

  typedef struct packed {
    logic ignore_fcs;
    logic [14:0] max_len;
    logic [7:0] min_len;
    logic [15:0] spacing;
    logic [rfc_pkg::LANES-1:0][63:0] pat;
  } rfc_cfg_s;

  typedef struct packed {
    rfc_cfg_s cfg;
    rfc_pkg::rfc_state_e st;
    rfc_pkg::rfc_state_e tail;
    logic [rfc_pkg::STAGE_WORDS-1:0][WORD_W-1:0] stage;
    logic [2:0] stage_n;
    logic [1:0] drain_i;
    logic [15:0] bytes;
    logic in_rdy;
    rfc_pkg::rfc_word_s out_w;
    logic out_v;
    logic st_bad_fcs;
    logic st_good;
    logic st_runt;
    logic st_over;
    logic [16:0] lane_cnt;
    logic [rfc_pkg::LANE_W-1:0] lane_id;
    logic locked;
  } rfc_top_s;

  rfc_top_s s_q;
  rfc_top_s s_d;

  rfc_stream_if #(.WIDTH(WORD_W), .LEVEL_W(rfc_pkg::LEVEL_W)) fin_if ();
  rfc_stream_if #(.WIDTH(WORD_W), .LEVEL_W(rfc_pkg::LEVEL_W)) fout_if ();

  rfc_fifo #(.WIDTH(WORD_W), .DEPTH(rfc_pkg::FIFO_DEPTH), .LEVEL_W(rfc_pkg::LEVEL_W)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .wr(fin_if.snk),
    .rd(fout_if.src)
  );

  // returns {hit, lane}; the highest matching lane wins if patterns overlap
  function automatic logic [rfc_pkg::LANE_W:0] lane_match(
    input logic [63:0] blk,
    input logic [rfc_pkg::LANES-1:0][63:0] pat
  );
    lane_match = '0;
    for (int i = 0; i < rfc_pkg::LANES; i++) begin
      if (((blk ^ pat[i]) & rfc_pkg::MARKER_CMP_MASK) == '0) begin
        lane_match = {1'b1, rfc_pkg::LANE_W'(i)};
      end
    end
  endfunction

  logic in_take;
  logic trunc_now;
  logic fin_eop;
  logic [15:0] nb;
  logic [15:0] new_len;
  logic [15:0] fin_len;
  logic [15:0] max16;
  logic [15:0] min16;
  rfc_pkg::rfc_word_s w;
  logic push;
  rfc_pkg::rfc_word_s push_w;
  logic [rfc_pkg::LANE_W:0] lm;
  logic lane_due;

  always_comb begin
    s_d = s_q;
    s_d.cfg.ignore_fcs = rx_ignore_fcs;
    s_d.cfg.max_len = rx_max_packet_len;
    s_d.cfg.min_len = rx_min_packet_len;
    s_d.cfg.spacing = rx_marker_spacing_less_one;
    s_d.cfg.pat = rx_lane_marker_pattern;
    s_d.st_bad_fcs = 1'b0;
    s_d.st_good = 1'b0;
    s_d.st_runt = 1'b0;
    s_d.st_over = 1'b0;

    in_take = in_valid && s_q.in_rdy;
    max16 = {1'b0, s_q.cfg.max_len};
    min16 = {8'h00, s_q.cfg.min_len};
    nb = in_eop ? WORD16 - 16'(in_mty) : WORD16;
    new_len = s_q.bytes + nb;
    // a packet that reaches the limit with more to come is already too long
    trunc_now = in_take && (s_q.st != rfc_pkg::ST_DISCARD) &&
                ((new_len > max16) || ((new_len == max16) && !in_eop));
    fin_len = trunc_now ? max16 : new_len;
    fin_eop = in_eop || trunc_now;
    w.data = in_data;
    w.sop = in_sop;
    w.eop = fin_eop;
    if (trunc_now) begin
      w.mty = rfc_pkg::MTY_W'(WORD16 - (max16 - s_q.bytes));
    end else begin
      w.mty = in_eop ? in_mty : '0;
    end
    w.err = fin_eop && (trunc_now ||
                        (in_eop && in_fcs_bad && !s_q.cfg.ignore_fcs) ||
                        (fin_len < min16));

    if (in_take && in_eop && in_fcs_bad) begin
      s_d.st_bad_fcs = 1'b1;
    end

    push = 1'b0;
    push_w = w;
    case (s_q.st)
      rfc_pkg::ST_GATHER: begin
        // hold up to one runt's worth so short packets never reach the fifo
        if (in_take) begin
          s_d.stage[s_q.stage_n[1:0]] = w;
          s_d.stage_n = s_q.stage_n + 3'd1;
          s_d.bytes = fin_len;
          if (fin_eop && (fin_len < RUNT16)) begin
            s_d.stage_n = '0;
            s_d.bytes = '0;
            s_d.st_runt = 1'b1;
          end else if (fin_eop) begin
            s_d.st = rfc_pkg::ST_DRAIN;
            s_d.tail = (trunc_now && !in_eop) ? rfc_pkg::ST_DISCARD : rfc_pkg::ST_GATHER;
            s_d.st_over = trunc_now;
            s_d.st_good = !trunc_now && (fin_len >= min16);
          end else if ((fin_len >= RUNT16) || (s_q.stage_n == 3'(rfc_pkg::STAGE_WORDS - 1))) begin
            s_d.st = rfc_pkg::ST_DRAIN;
            s_d.tail = rfc_pkg::ST_PASS;
          end
        end
      end
      rfc_pkg::ST_DRAIN: begin
        push = 1'b1;
        push_w = s_q.stage[s_q.drain_i];
        if (fin_if.ready) begin
          s_d.drain_i = s_q.drain_i + 2'd1;
          if (3'(s_q.drain_i) == s_q.stage_n - 3'd1) begin
            s_d.st = s_q.tail;
            s_d.drain_i = '0;
            s_d.stage_n = '0;
            if (s_q.tail != rfc_pkg::ST_PASS) begin
              s_d.bytes = '0;
            end
          end
        end
      end
      rfc_pkg::ST_PASS: begin
        // room was promised when in_ready was raised
        if (in_take) begin
          push = 1'b1;
          s_d.bytes = fin_len;
          if (fin_eop) begin
            s_d.bytes = '0;
            s_d.st = (trunc_now && !in_eop) ? rfc_pkg::ST_DISCARD : rfc_pkg::ST_GATHER;
            s_d.st_over = trunc_now;
            s_d.st_good = !trunc_now && (fin_len >= min16);
          end
        end
      end
      rfc_pkg::ST_DISCARD: begin
        if (in_take && in_eop) begin
          s_d.st = rfc_pkg::ST_GATHER;
        end
      end
      default: begin
        s_d.st = rfc_pkg::ST_GATHER;
      end
    endcase

    // conservative by one slot so a registered ready never overruns
    case (s_d.st)
      rfc_pkg::ST_DRAIN: s_d.in_rdy = 1'b0;
      rfc_pkg::ST_PASS: s_d.in_rdy =
        ({1'b0, fin_if.level} + (rfc_pkg::LEVEL_W+1)'(push)) < (rfc_pkg::LEVEL_W+1)'(rfc_pkg::FIFO_DEPTH - 1);
      default: s_d.in_rdy = 1'b1;
    endcase

    if (fout_if.valid && fout_if.ready) begin
      s_d.out_w = fout_if.data;
      s_d.out_v = 1'b1;
    end else if (rx_user_ready) begin
      s_d.out_v = 1'b0;
    end

    lm = lane_match(lane_blk_data, s_q.cfg.pat);
    // >= so that shrinking the spacing mid-count still checks the next block
    lane_due = (s_q.lane_cnt >= ({1'b0, s_q.cfg.spacing} + 17'd1));
    if (lane_blk_valid) begin
      if (!s_q.locked) begin
        if (lm[rfc_pkg::LANE_W]) begin
          s_d.locked = 1'b1;
          s_d.lane_id = lm[rfc_pkg::LANE_W-1:0];
          s_d.lane_cnt = '0;
        end
      end else if (lane_due) begin
        if (lm[rfc_pkg::LANE_W] && (lm[rfc_pkg::LANE_W-1:0] == s_q.lane_id)) begin
          s_d.lane_cnt = '0;
        end else begin
          s_d.locked = 1'b0;
        end
      end else begin
        s_d.lane_cnt = s_q.lane_cnt + 17'd1;
      end
    end
  end

  assign fin_if.valid = push;
  assign fin_if.data = push_w;
  assign fout_if.ready = !s_q.out_v || rx_user_ready;
  assign fout_if.level = fin_if.level;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.cfg.max_len <= rfc_pkg::MAX_LEN_RST;
      s_q.cfg.min_len <= rfc_pkg::MIN_LEN_RST;
      s_q.cfg.spacing <= rfc_pkg::SPACING_RST;
      s_q.cfg.pat <= rfc_pkg::MARKER_RST;
      s_q.st <= rfc_pkg::ST_GATHER;
      s_q.tail <= rfc_pkg::ST_GATHER;
      s_q.in_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.in_rdy;
  assign rx_user_valid_out = s_q.out_v;
  assign rx_user_data_out = s_q.out_w.data;
  assign rx_user_mty_out = s_q.out_w.mty;
  assign rx_user_sop_out = s_q.out_w.sop;
  assign rx_user_eop_out = s_q.out_w.eop;
  assign rx_user_err_out = s_q.out_w.err;
  assign stat_rx_bad_fcs = s_q.st_bad_fcs;
  assign stat_rx_good_pkt = s_q.st_good;
  assign stat_rx_runt_drop = s_q.st_runt;
  assign stat_rx_oversize = s_q.st_over;
  assign lane_locked_out = s_q.locked;
  assign lane_id_out = s_q.lane_id;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_fcs_end;
    in_take && in_eop && in_fcs_bad && (s_q.st != rfc_pkg::ST_DISCARD);
  endsequence
  sequence s_trunc_open;
    trunc_now && !in_eop;
  endsequence

  chk_fcs_err_set: assert property (
    s_fcs_end and !s_q.cfg.ignore_fcs |-> w.eop && w.err)
    else $error("bad fcs packet ended without error");
  chk_fcs_ignored: assert property (
    s_fcs_end and s_q.cfg.ignore_fcs && !trunc_now && (fin_len >= min16) |-> !w.err)
    else $error("error raised for bad fcs while fcs is ignored");
  chk_fcs_stat_good: assert property (
    s_fcs_end and (s_q.st == rfc_pkg::ST_PASS) && !trunc_now && (fin_len >= min16)
    |=> stat_rx_bad_fcs && stat_rx_good_pkt)
    else $error("bad fcs packet not reported good with bad fcs pulse");
  chk_trunc_len: assert property (
    trunc_now |-> (fin_len == max16) && w.eop && w.err)
    else $error("oversize packet not cut at maximum length");
  chk_trunc_tail: assert property (
    s_trunc_open |=> ((s_q.st == rfc_pkg::ST_DISCARD) ||
                      ((s_q.st == rfc_pkg::ST_DRAIN) && (s_q.tail == rfc_pkg::ST_DISCARD))) && stat_rx_oversize)
    else $error("oversize tail not discarded");
  chk_runt_drop: assert property (
    (s_q.st == rfc_pkg::ST_GATHER) && in_take && fin_eop && (fin_len < RUNT16)
    |=> stat_rx_runt_drop && (s_q.stage_n == 3'd0) && (s_q.st == rfc_pkg::ST_GATHER))
    else $error("runt packet was not dropped");
  chk_undersize_err: assert property (
    in_take && fin_eop && (fin_len < min16) |-> w.err)
    else $error("undersize packet ended without error");
  chk_cfg_defaults: assert property (
    $fell(reset) |-> (s_q.cfg.spacing == rfc_pkg::SPACING_RST) && (s_q.cfg.pat == rfc_pkg::MARKER_RST))
    else $error("marker settings not at reset values");
  chk_lane_lock: assert property (
    !s_q.locked && lane_blk_valid && lm[rfc_pkg::LANE_W]
    |=> lane_locked_out && (lane_id_out == $past(lm[rfc_pkg::LANE_W-1:0])) ##1 lane_locked_out)
    else $error("lane did not lock on a marker");
  chk_lane_loss: assert property (
    s_q.locked && lane_blk_valid && lane_due && !lm[rfc_pkg::LANE_W] |=> !lane_locked_out)
    else $error("missing marker did not drop lane lock");
  chk_out_hold: assert property (
    rx_user_valid_out && !rx_user_ready |=> rx_user_valid_out && $stable(rx_user_data_out))
    else $error("user output changed while stalled");
endmodule

// >>> bench/rfc_user_sink.sv
`timescale 1ns/100ps
module rfc_user_sink (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow,
  input wire logic valid,
  input wire logic [rfc_pkg::DATA_BYTES*8-1:0] data,
  input wire logic [rfc_pkg::MTY_W-1:0] mty,
  input wire logic sop,
  input wire logic eop,
  input wire logic err,
  output logic ready,
  output logic [15:0] pkt_len,
  output logic pkt_err,
  output logic [15:0] pkt_cnt,
  output logic [15:0] bad_cnt
);
  logic [15:0] pos_q;
  logic [1:0] tick_q;
  int n;
  int base;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ready <= 1'b0;
      pkt_len <= 16'h0000;
      pkt_err <= 1'b0;
      pkt_cnt <= 16'h0000;
      bad_cnt <= 16'h0000;
      pos_q <= 16'h0000;
      tick_q <= 2'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
      // slow mode takes one word in four, so the fifo backs up into in_ready
      ready <= !slow || tick_q == 2'h3;
      if (valid && ready) begin
        base = sop ? 0 : int'(pos_q);
        n = eop ? 16 - int'(mty) : 16;
        for (int b = 0; b < n; b++) begin
          if (data[8*b +: 8] !== 8'(base + b)) bad_cnt <= bad_cnt + 16'h1;
        end
        // error is only meaningful on the last word
        if (err && !eop) bad_cnt <= bad_cnt + 16'h1;
        pos_q <= eop ? 16'h0000 : 16'(base + 16);
        if (eop) begin
          pkt_len <= 16'(base + n);
          pkt_err <= err;
          pkt_cnt <= pkt_cnt + 16'h1;
        end
      end
    end
  end
endmodule

// >>> bench/tb_rfc_rx_check.sv
`timescale 1ns/100ps
module tb_rfc_rx_check;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ign = 1'b0;
  logic [14:0] max_len = rfc_pkg::MAX_LEN_RST;
  logic [7:0] min_len = rfc_pkg::MIN_LEN_RST;
  logic [15:0] spacing = rfc_pkg::SPACING_RST;
  logic [rfc_pkg::LANES-1:0][63:0] pats = rfc_pkg::MARKER_RST;
  logic in_valid = 1'b0;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic in_fcs_bad = 1'b0;
  logic [rfc_pkg::DATA_BYTES*8-1:0] in_data = '0;
  logic [rfc_pkg::MTY_W-1:0] in_mty = '0;
  logic blk_v = 1'b0;
  logic [63:0] blk_d = 64'h0;
  logic slow = 1'b0;
  logic in_ready, u_valid, u_sop, u_eop, u_err, u_ready, s_bad, s_good, s_runt, s_over, locked;
  logic [rfc_pkg::DATA_BYTES*8-1:0] u_data;
  logic [rfc_pkg::MTY_W-1:0] u_mty;
  logic [rfc_pkg::LANE_W-1:0] lane_id;
  logic [15:0] pkt_len, pkt_cnt, bad_cnt;
  logic pkt_err;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_good = 0, n_bad = 0, n_runt = 0, n_over = 0;

  rfc_rx_check i_dut (.mclk(mclk), .reset(reset), .rx_ignore_fcs(ign), .rx_max_packet_len(max_len),
    .rx_min_packet_len(min_len), .rx_marker_spacing_less_one(spacing), .rx_lane_marker_pattern(pats),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_mty(in_mty), .in_sop(in_sop),
    .in_eop(in_eop), .in_fcs_bad(in_fcs_bad), .rx_user_ready(u_ready), .rx_user_valid_out(u_valid),
    .rx_user_data_out(u_data), .rx_user_mty_out(u_mty), .rx_user_sop_out(u_sop), .rx_user_eop_out(u_eop),
    .rx_user_err_out(u_err), .stat_rx_bad_fcs(s_bad), .stat_rx_good_pkt(s_good), .stat_rx_runt_drop(s_runt),
    .stat_rx_oversize(s_over), .lane_blk_valid(blk_v), .lane_blk_data(blk_d), .lane_locked_out(locked),
    .lane_id_out(lane_id));

  rfc_user_sink i_sink (.mclk(mclk), .reset(reset), .slow(slow), .valid(u_valid), .data(u_data), .mty(u_mty),
    .sop(u_sop), .eop(u_eop), .err(u_err), .ready(u_ready), .pkt_len(pkt_len), .pkt_err(pkt_err),
    .pkt_cnt(pkt_cnt), .bad_cnt(bad_cnt));

  always #2.5 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    n_good += (s_good === 1'b1);
    n_bad += (s_bad === 1'b1);
    n_runt += (s_runt === 1'b1);
    n_over += (s_over === 1'b1);
    if (cycles == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic send(input int len, input logic bad);
    int k;
    int n;
    k = 0;
    while (k < len) begin
      n = (len - k > 16) ? 16 : len - k;
      for (int b = 0; b < 16; b++) in_data[8*b +: 8] <= 8'(k + b);
      in_valid <= 1'b1;
      in_sop <= (k == 0);
      in_eop <= (k + n == len);
      in_mty <= 4'(16 - n);
      in_fcs_bad <= bad;
      @(negedge mclk);
      while (in_ready !== 1'b1) @(negedge mclk);
      @(posedge mclk);
      k += n;
    end
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask

  task automatic pkt(input int len, input logic bad, input int exp_len, input logic exp_err);
    logic [15:0] c0;
    int t;
    c0 = pkt_cnt;
    send(len, bad);
    t = 0;
    while (pkt_cnt === c0 && t < 150) begin
      @(posedge mclk);
      t++;
    end
    check("delivered", 64'(pkt_cnt - c0), 64'(exp_len != 0));
    if (exp_len != 0) begin
      check("length", 64'(pkt_len), 64'(exp_len));
      check("error", 64'(pkt_err), 64'(exp_err));
    end
    repeat (4) @(posedge mclk);
  endtask

  task automatic stats(input int g, input int b, input int r, input int o);
    check("good", n_good, g);
    check("bad fcs", n_bad, b);
    check("runt", n_runt, r);
    check("oversize", n_over, o);
  endtask

  task automatic blk(input logic [63:0] d, input int rep);
    repeat (rep) begin
      blk_v <= 1'b1;
      blk_d <= d;
      @(posedge mclk);
    end
  endtask

  task automatic idle();
    blk_v <= 1'b0;
    blk_d <= ~blk_d;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    check("ready in reset", in_ready, 1'b1);
    check("valid in reset", u_valid, 1'b0);
    check("lock in reset", locked, 1'b0);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    pkt(100, 1'b0, 100, 1'b0);
    pkt(64, 1'b0, 64, 1'b0);
    pkt(63, 1'b0, 0, 1'b0);
    pkt(100, 1'b1, 100, 1'b1);
    stats(3, 1, 1, 0);
    ign <= 1'b1;
    repeat (2) @(posedge mclk);
    pkt(80, 1'b1, 80, 1'b0);
    ign <= 1'b0;
    // kept inside 64..16383 with bit 14 clear, and min below max
    max_len <= 15'h0064;
    min_len <= 8'h50;
    repeat (2) @(posedge mclk);
    pkt(130, 1'b0, 100, 1'b1);
    pkt(100, 1'b0, 100, 1'b0);
    pkt(70, 1'b0, 70, 1'b1);
    pkt(80, 1'b0, 80, 1'b0);
    slow <= 1'b1;
    pkt(200, 1'b1, 100, 1'b1);
    slow <= 1'b0;
    stats(6, 3, 1, 2);
    check("payload", bad_cnt, 16'h0000);
    // default spacing: 16384 data blocks between markers
    blk(pats[0], 1);
    blk(64'h0, 16384);
    blk(pats[0], 1);
    idle();
    check("lock default spacing", locked, 1'b1);
    spacing <= 16'h0003;
    pats[3] <= 64'h1122330044556600;
    repeat (2) @(posedge mclk);
    blk(64'h0, 32);
    idle();
    check("lock lost", locked, 1'b0);
    for (int l = 0; l < rfc_pkg::LANES; l++) begin
      blk(pats[l], 1);
      blk(64'h0, 4);
      blk(pats[l], 1);
      idle();
      check("locked", locked, 1'b1);
      check("lane id", 64'(lane_id), 64'(l));
      blk(64'h0, 5);
      idle();
      check("unlocked", locked, 1'b0);
    end
    blk(rfc_pkg::MARKER_RST[3], 1);
    idle();
    check("old pattern", locked, 1'b0);
    final_report();
  end
endmodule
